// File: hw/cms_clk_switch.sv
// Glitch-free source switch sequencer for one clock mux.
// Assumes a downstream mux that honours gate_o low while sel_o changes.
`timescale 1ns/1ps
module cms_clk_switch #(
	parameter int W = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] req_sel_i,
	input wire logic req_ok_i,
	output logic [W-1:0] sel_o,
	output logic gate_o
);

	typedef enum logic [1:0] {
		CMS_SW_RUN = 2'b00,
		CMS_SW_STOP = 2'b01,
		CMS_SW_START = 2'b10
	} cms_sw_e;

	cms_sw_e st_ff;
	cms_sw_e nxt_st;
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic [W-1:0] sel_ff;
	logic [W-1:0] nxt_sel;
	logic gate_ff;
	logic nxt_gate;
	wire cnt_done = (cnt_ff == 3'(cms_pkg::SWITCH_GAP_CYC - 1));

	// Gate off, wait, swap, wait, gate on: no runt pulse reaches the sinks
	always_comb
	begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff + 3'h1;
		nxt_sel = sel_ff;
		nxt_gate = gate_ff;
		case (st_ff)
			CMS_SW_RUN:
			begin
				nxt_cnt = 3'h0;
				if (req_ok_i && req_sel_i != sel_ff)
				begin
					nxt_gate = 1'b0;
					nxt_st = CMS_SW_STOP;
				end
			end
			CMS_SW_STOP:
			begin
				if (cnt_done)
				begin
					nxt_cnt = 3'h0;
					nxt_sel = req_sel_i;
					nxt_st = CMS_SW_START;
				end
			end
			CMS_SW_START:
			begin
				if (cnt_done)
				begin
					nxt_gate = 1'b1;
					nxt_st = CMS_SW_RUN;
				end
			end
			default:
			begin
				nxt_st = CMS_SW_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_ff <= CMS_SW_RUN;
			cnt_ff <= 3'h0;
			sel_ff <= '0;
			gate_ff <= 1'b1;
		end
		else
		begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sel_ff <= nxt_sel;
			gate_ff <= nxt_gate;
		end
	end

	assign sel_o = sel_ff;
	assign gate_o = gate_ff;

endmodule : cms_clk_switch

// File: hw/cms_clock_ctrl.sv
// Clock multiplier control and system / USB clock source selection.
// Assumes an 8-bit SFR bus on clk_i and analog oscillators and a
// multiplier loop whose status pins are asynchronous to clk_i.
`timescale 1ns/1ps

//Contract
//- Multiplier outputs four times its input
//- Halved multiplier output selectable as system clock
//- Bit 7 gates multiplier enable
//- Init bit zero at enable; later one initializes
//- Source 00 internal, 01 external, 10 half
//- Crystal valid set once oscillator settles
//- Internal oscillator usable immediately after enable
//- System select picks external only at 01
//- External oscillator still routable to peripherals
//- Glitch-free runtime switch among ready sources; readiness is checked only when a switch starts, not at the swap
//- USB select: multiplier at 000, divided oscillators
module cms_clock_ctrl (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic xosc_settled_i,
	input wire logic mult_lock_i,
	output logic multiplier_enable_o,
	output logic multiplier_initialize_o,
	output logic [1:0] multiplier_source_select_o,
	output logic [2:0] mult_ratio_o,
	output logic [1:0] sysclk_source_select_o,
	output logic sysclk_gate_o,
	output logic [2:0] usb_clock_source_select_o,
	output logic usb_clock_source_select_gate_o,
	output logic int_osc_enable_o,
	output logic [1:0] internal_osc_divide_o,
	output logic [2:0] external_osc_mode_o,
	output logic [2:0] external_osc_freq_range_o,
	output logic ext_osc_periph_en_o
);

	typedef enum logic [2:0] {
		CMS_M_OFF = 3'b000,
		CMS_M_WARM = 3'b001,
		CMS_M_READY = 3'b010,
		CMS_M_INIT = 3'b011,
		CMS_M_LOCKED = 3'b100
	} cms_mul_e;

	// Reset release
	logic [1:0] rst_sync_ff;
	wire rst_n = rst_sync_ff[1];

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	// Status pins cross in through two flops each
	wire [1:0] pin_async = {mult_lock_i, xosc_settled_i};
	logic [1:0] pin_meta_ff;
	logic [1:0] pin_sync_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_sync
			always_ff @(posedge clk_i or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pin_meta_ff[gi] <= 1'b0;
					pin_sync_ff[gi] <= 1'b0;
				end
				else
				begin
					pin_meta_ff[gi] <= pin_async[gi];
					pin_sync_ff[gi] <= pin_meta_ff[gi];
				end
			end
		end
	endgenerate

	wire xosc_settled = pin_sync_ff[0];
	wire loop_locked = pin_sync_ff[1];

	// Register file
	logic [7:0] mul_ctrl_ff;
	logic [7:0] clk_sel_ff;
	logic [7:0] xosc_ctrl_ff;
	logic [7:0] iosc_ctrl_ff;

	wire wr_mul = sfr_wr_i && (sfr_addr_i == cms_pkg::ADDR_MULT_CTRL);
	wire wr_clk = sfr_wr_i && (sfr_addr_i == cms_pkg::ADDR_CLK_SEL);
	wire wr_xosc = sfr_wr_i && (sfr_addr_i == cms_pkg::ADDR_XOSC_CTRL);
	wire wr_iosc = sfr_wr_i && (sfr_addr_i == cms_pkg::ADDR_IOSC_CTRL);

	wire [1:0] wr_src = sfr_wdata_i[cms_pkg::MUL_SRC_LSB +: 2];
	wire mul_en = mul_ctrl_ff[cms_pkg::MUL_EN_BIT];
	wire wr_en = sfr_wdata_i[cms_pkg::MUL_EN_BIT];
	wire wr_init = sfr_wdata_i[cms_pkg::MUL_INIT_BIT];
	// Reserved source code keeps the previous selection
	wire [1:0] nxt_src = (wr_src == cms_pkg::MSRC_RSVD) ?
		mul_ctrl_ff[cms_pkg::MUL_SRC_LSB +: 2] : wr_src;
	wire mul_clear = wr_mul && (sfr_wdata_i == 8'h00);
	// Init only counts from an already enabled multiplier
	wire init_req = wr_mul && mul_en && wr_en && wr_init &&
		!mul_ctrl_ff[cms_pkg::MUL_INIT_BIT];

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mul_ctrl_ff <= cms_pkg::RST_MULT_CTRL;
			clk_sel_ff <= cms_pkg::RST_CLK_SEL;
			xosc_ctrl_ff <= cms_pkg::RST_XOSC_CTRL;
			iosc_ctrl_ff <= cms_pkg::RST_IOSC_CTRL;
		end
		else
		begin
			if (wr_mul)
				mul_ctrl_ff <= (sfr_wdata_i & cms_pkg::MUL_WR_MASK & 8'hFC) |
					{6'h00, nxt_src};
			if (wr_clk)
				clk_sel_ff <= sfr_wdata_i;
			if (wr_xosc)
				xosc_ctrl_ff <= sfr_wdata_i;
			if (wr_iosc)
				iosc_ctrl_ff <= sfr_wdata_i;
		end
	end

	// Multiplier sequencer
	cms_mul_e mst_ff;
	cms_mul_e nxt_mst;
	logic [8:0] mcnt_ff;
	logic [8:0] nxt_mcnt;
	wire warm_done = (mcnt_ff >= 9'(cms_pkg::WARM_CYC - 1));
	wire lock_done = (mcnt_ff >= 9'(cms_pkg::LOCK_CYC - 1));
	wire mul_locked = (mst_ff == CMS_M_LOCKED);

	always_comb
	begin
		nxt_mst = mst_ff;
		nxt_mcnt = (mcnt_ff == 9'h1FF) ? mcnt_ff : mcnt_ff + 9'h001;
		case (mst_ff)
			CMS_M_OFF:
			begin
				nxt_mcnt = 9'h000;
				if (wr_mul && wr_en)
					nxt_mst = CMS_M_WARM;
			end
			CMS_M_WARM:
			begin
				// Init write counts only in the cycle warm-up ends; an earlier one is dropped
				if (warm_done)
					nxt_mst = CMS_M_READY;
				if (init_req && warm_done)
				begin
					nxt_mcnt = 9'h000;
					nxt_mst = CMS_M_INIT;
				end
			end
			CMS_M_READY:
			begin
				if (init_req)
				begin
					nxt_mcnt = 9'h000;
					nxt_mst = CMS_M_INIT;
				end
			end
			CMS_M_INIT:
			begin
				if (lock_done && loop_locked)
					nxt_mst = CMS_M_LOCKED;
			end
			CMS_M_LOCKED:
			begin
				// Loss of lock sends the loop back to settle
				if (!loop_locked)
				begin
					nxt_mcnt = 9'h000;
					nxt_mst = CMS_M_INIT;
				end
			end
			default:
			begin
				nxt_mst = CMS_M_OFF;
			end
		endcase
		if (mul_clear || (wr_mul && !wr_en))
		begin
			nxt_mst = CMS_M_OFF;
			nxt_mcnt = 9'h000;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mst_ff <= CMS_M_OFF;
			mcnt_ff <= 9'h000;
		end
		else
		begin
			mst_ff <= nxt_mst;
			mcnt_ff <= nxt_mcnt;
		end
	end

	// Oscillator readiness
	wire iosc_en = iosc_ctrl_ff[cms_pkg::IEN_BIT];
	wire [2:0] xmode = xosc_ctrl_ff[cms_pkg::XMODE_LSB +: 3];
	wire xosc_en = (xmode != 3'h0);
	wire xtal_valid = xosc_en && xosc_settled;

	// Source is fit to drive a clock tree
	function automatic logic src_ok(input logic [2:0] kind,
		input logic i_ok, input logic x_ok, input logic m_ok);
		logic r;
		r = 1'b0;
		case (kind)
			3'h0: r = i_ok;
			3'h1: r = x_ok;
			3'h2: r = m_ok;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : src_ok

	// Internal oscillator needs no settling wait
	wire iosc_ok = iosc_en;
	wire [1:0] sys_req = clk_sel_ff[cms_pkg::SYS_SEL_LSB +: 2];
	wire [2:0] usb_req = clk_sel_ff[cms_pkg::USB_SEL_LSB +: 3];
	wire [2:0] sys_kind = (sys_req == cms_pkg::SYS_INT) ? 3'h0 :
		(sys_req == cms_pkg::SYS_EXT) ? 3'h1 :
		(sys_req == cms_pkg::SYS_MUL_D2) ? 3'h2 : 3'h7;
	wire [2:0] usb_kind = (usb_req == cms_pkg::USB_MUL) ? 3'h2 :
		(usb_req == cms_pkg::USB_INT_DIV) ? 3'h0 :
		(usb_req <= cms_pkg::USB_EXT_D4) ? 3'h1 : 3'h7;
	wire sys_ok = src_ok(sys_kind, iosc_ok, xtal_valid, mul_locked);
	wire usb_ok = src_ok(usb_kind, iosc_ok, xtal_valid, mul_locked);

	// Unready or reserved picks made in CMS_SW_RUN leave the running source in place; one made in CMS_SW_STOP is swapped in unchecked
	logic [1:0] sys_sel;
	logic sys_gate;
	logic [2:0] usb_sel;
	logic usb_gate;

	cms_clk_switch #(
		.W(2)
	) u_sys_switch (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.req_sel_i(sys_req),
		.req_ok_i(sys_ok),
		.sel_o(sys_sel),
		.gate_o(sys_gate)
	);

	cms_clk_switch #(
		.W(3)
	) u_usb_switch (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.req_sel_i(usb_req),
		.req_ok_i(usb_ok),
		.sel_o(usb_sel),
		.gate_o(usb_gate)
	);

	// Read path
	logic [7:0] rd_mux;
	assign rd_mux =
		(sfr_addr_i == cms_pkg::ADDR_MULT_CTRL) ?
			(mul_ctrl_ff | {2'h0, mul_locked, 5'h00}) :
		(sfr_addr_i == cms_pkg::ADDR_CLK_SEL) ? clk_sel_ff :
		(sfr_addr_i == cms_pkg::ADDR_XOSC_CTRL) ?
			(xosc_ctrl_ff & 8'h7F) | {xtal_valid, 7'h00} :
		(sfr_addr_i == cms_pkg::ADDR_IOSC_CTRL) ?
			(iosc_ctrl_ff & 8'hBF) | {1'b0, iosc_ok, 6'h00} : 8'h00;

	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sfr_rdata_o <= 8'h00;
			multiplier_enable_o <= 1'b0;
			multiplier_initialize_o <= 1'b0;
			multiplier_source_select_o <= cms_pkg::MSRC_INT;
			mult_ratio_o <= cms_pkg::MULT_RATIO;
			sysclk_source_select_o <= cms_pkg::SYS_INT;
			sysclk_gate_o <= 1'b1;
			usb_clock_source_select_o <= cms_pkg::USB_MUL;
			usb_clock_source_select_gate_o <= 1'b1;
			int_osc_enable_o <= 1'b1;
			internal_osc_divide_o <= 2'h0;
			external_osc_mode_o <= 3'h0;
			external_osc_freq_range_o <= 3'h0;
			ext_osc_periph_en_o <= 1'b0;
		end
		else
		begin
			if (sfr_rd_i)
				sfr_rdata_o <= rd_mux;
			multiplier_enable_o <= (mst_ff != CMS_M_OFF);
			multiplier_initialize_o <= (mst_ff == CMS_M_INIT) ||
				mul_locked;
			multiplier_source_select_o <=
				mul_ctrl_ff[cms_pkg::MUL_SRC_LSB +: 2];
			mult_ratio_o <= cms_pkg::MULT_RATIO;
			sysclk_source_select_o <= sys_sel;
			sysclk_gate_o <= sys_gate;
			usb_clock_source_select_o <= usb_sel;
			usb_clock_source_select_gate_o <= usb_gate;
			int_osc_enable_o <= iosc_en;
			internal_osc_divide_o <= iosc_ctrl_ff[cms_pkg::IDIV_LSB +: 2];
			external_osc_mode_o <= xmode;
			external_osc_freq_range_o <=
				xosc_ctrl_ff[cms_pkg::XFREQ_LSB +: 3];
			// Peripheral path follows the oscillator, not the system pick
			ext_osc_periph_en_o <= xtal_valid;
		end
	end

endmodule : cms_clock_ctrl

// File: inc/cms_pkg.sv
// Constants for the clock multiplier and clock source select block.
// Assumes an 8-bit special function register bus clocked at 40 MHz.
package cms_pkg;

	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_MULT_CTRL = 8'hB9;
	localparam logic [7:0] ADDR_CLK_SEL = 8'hA9;
	localparam logic [7:0] ADDR_XOSC_CTRL = 8'hB1;
	localparam logic [7:0] ADDR_IOSC_CTRL = 8'hB2;

	// Reset values
	localparam logic [7:0] RST_MULT_CTRL = 8'h00;
	localparam logic [7:0] RST_CLK_SEL = 8'h00;
	localparam logic [7:0] RST_XOSC_CTRL = 8'h00;
	localparam logic [7:0] RST_IOSC_CTRL = 8'h80;

	// Multiplier control fields
	localparam int MUL_EN_BIT = 7;
	localparam int MUL_INIT_BIT = 6;
	localparam int MUL_LOCK_BIT = 5;
	localparam int MUL_SRC_LSB = 0;
	localparam logic [7:0] MUL_WR_MASK = 8'hC3;

	// Clock select fields
	localparam int SYS_SEL_LSB = 0;
	localparam int USB_SEL_LSB = 4;

	// External oscillator control fields
	localparam int XVLD_BIT = 7;
	localparam int XMODE_LSB = 4;
	localparam int XFREQ_LSB = 0;

	// Internal oscillator control fields
	localparam int IEN_BIT = 7;
	localparam int IRDY_BIT = 6;
	localparam int IDIV_LSB = 0;

	// Multiplier source codes
	localparam logic [1:0] MSRC_INT = 2'h0;
	localparam logic [1:0] MSRC_EXT = 2'h1;
	localparam logic [1:0] MSRC_EXT_D2 = 2'h2;
	localparam logic [1:0] MSRC_RSVD = 2'h3;

	// System clock source codes
	localparam logic [1:0] SYS_INT = 2'h0;
	localparam logic [1:0] SYS_EXT = 2'h1;
	localparam logic [1:0] SYS_MUL_D2 = 2'h2;

	// USB clock source codes
	localparam logic [2:0] USB_MUL = 3'h0;
	localparam logic [2:0] USB_INT_DIV = 3'h1;
	localparam logic [2:0] USB_EXT = 3'h2;
	localparam logic [2:0] USB_EXT_D2 = 3'h3;
	localparam logic [2:0] USB_EXT_D4 = 3'h4;

	// Multiplication factor handed to the analog loop
	localparam logic [2:0] MULT_RATIO = 3'h4;

	// Timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int T_WARM_NS = 5;
	localparam int T_LOCK_US = 10;
	localparam int WARM_CYC = (T_WARM_NS * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int LOCK_CYC = (T_LOCK_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int SWITCH_GAP_CYC = 4;

endpackage : cms_pkg

// File: tb/cms_ctrl_props.sv
// Port-level checker for the clock control block.
// Assumes binding onto cms_clock_ctrl; single clock domain.
`timescale 1ns/1ps
module cms_ctrl_props (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic multiplier_enable_o,
	input wire logic multiplier_initialize_o,
	input wire logic [1:0] multiplier_source_select_o,
	input wire logic [2:0] mult_ratio_o,
	input wire logic [1:0] sysclk_source_select_o,
	input wire logic sysclk_gate_o,
	input wire logic [2:0] usb_clock_source_select_o,
	input wire logic usb_clock_source_select_gate_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [8:0] en_cnt_ff;
	logic b9_wr;
	assign b9_wr = sfr_wr_i && sfr_addr_i == 8'hB9;
	// Saturates so a long enable never wraps to a small count
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			en_cnt_ff <= 9'h000;
		else if (!multiplier_enable_o)
			en_cnt_ff <= 9'h000;
		else if (en_cnt_ff != 9'h1FF)
			en_cnt_ff <= en_cnt_ff + 9'h001;
	end
	a_ratio_four: assert property (mult_ratio_o == 3'h4)
		else $error("ratio not four");
	a_rsvd_bits_zero: assert property (sfr_rd_i && sfr_addr_i == 8'hB9
		|=> sfr_rdata_o[4:2] == 3'h0) else $error("bits 4:2 not zero");
	a_enable_drops: assert property (b9_wr && !sfr_wdata_i[7]
		|-> ##[1:3] !multiplier_enable_o) else $error("enable stays");
	a_init_needs_en: assert property (multiplier_initialize_o
		|-> multiplier_enable_o) else $error("init without enable");
	a_init_after_warm: assert property ($rose(multiplier_initialize_o)
		|-> en_cnt_ff >= 9'h0C6) else $error("init before warm-up");
	a_zero_clears: assert property (b9_wr && sfr_wdata_i == 8'h00
		|-> ##[1:3] !multiplier_initialize_o) else $error("init kept");
	a_src_no_rsvd: assert property (multiplier_source_select_o != 2'h3)
		else $error("reserved source");
	a_sys_no_rsvd: assert property (sysclk_source_select_o != 2'h3)
		else $error("reserved sys code");
	a_sys_switch_gated: assert property ($changed(sysclk_source_select_o)
		|-> !sysclk_gate_o && !$past(sysclk_gate_o)) else $error("sys glitch");
	a_usb_switch_gated: assert property ($changed(usb_clock_source_select_o)
		|-> !usb_clock_source_select_gate_o && !$past(usb_clock_source_select_gate_o)) else $error("usb glitch");
	a_usb_code_legal: assert property (usb_clock_source_select_o <= 3'h4)
		else $error("reserved usb code");
endmodule : cms_ctrl_props

bind cms_clock_ctrl cms_ctrl_props u_props (.clk_i, .reset_n_i, .sfr_addr_i,
	.sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .multiplier_enable_o,
	.multiplier_initialize_o, .multiplier_source_select_o, .mult_ratio_o,
	.sysclk_source_select_o, .sysclk_gate_o, .usb_clock_source_select_o,
	.usb_clock_source_select_gate_o);

// File: tb/cms_osc_model.sv
// Behavioural crystal oscillator and multiplier loop.
// Assumes mode and init come straight from the block under test.
`timescale 1ns/1ps
module cms_osc_model #(
	parameter int SETTLE_CYC = 300,
	parameter int LOCK_CYC = 500
) (
	input wire logic clk_i,
	input wire logic [2:0] xmode_i,
	input wire logic init_i,
	output logic settled_o,
	output logic locked_o
);
	int xcnt = 0;
	int lcnt = 0;
	always @(posedge clk_i)
	begin
		xcnt <= (xmode_i == 3'h0) ? 0 : xcnt + 1;
		lcnt <= init_i ? lcnt + 1 : 0;
	end
	// Mode zero stops the crystal, so settling restarts
	assign settled_o = xcnt >= SETTLE_CYC;
	// Lock only follows an init and falls with it
	assign locked_o = lcnt >= LOCK_CYC;
endmodule : cms_osc_model

// File: tb/tb.sv
// Self-checking bench for the clock control block.
// Assumes the oscillator model drives the status pins.
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic xs, ml, m_en, m_init, s_gate, u_gate, i_en, periph;
	logic [1:0] m_src, s_sel, idiv;
	logic [2:0] ratio, u_sel, xmode, xrange;
	logic [7:0] regs [256];
	logic [7:0] rlist [5] = '{8'hB9, 8'hA9, 8'hB1, 8'hB2, 8'hBA};
	logic [7:0] d;
	int mismatches = 0;
	int checked = 0;
	int k;
	always #12.5 clk_i = ~clk_i;
	cms_clock_ctrl dut (.clk_i, .reset_n_i, .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata), .xosc_settled_i(xs), .mult_lock_i(ml),
		.multiplier_enable_o(m_en), .multiplier_initialize_o(m_init),
		.multiplier_source_select_o(m_src), .mult_ratio_o(ratio),
		.sysclk_source_select_o(s_sel), .sysclk_gate_o(s_gate),
		.usb_clock_source_select_o(u_sel), .usb_clock_source_select_gate_o(u_gate),
		.int_osc_enable_o(i_en), .internal_osc_divide_o(idiv),
		.external_osc_mode_o(xmode), .external_osc_freq_range_o(xrange),
		.ext_osc_periph_en_o(periph));
	cms_osc_model osc (.clk_i, .xmode_i(xmode), .init_i(m_init),
		.settled_o(xs), .locked_o(ml));
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] s);
	begin
		checked++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	end
	endtask : chk
	task automatic wrap_up;
	begin
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask : wrap_up
	// Reference model: expected read-back value of each register after a write
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] o;
	begin
		o = regs[a];
		if (a == 8'hA9)
			regs[a] = v & 8'h73;
		if (a == 8'hB1)
			regs[a] = {o[7] & (v[6:4] != 3'h0), v[6:4], 1'b0, v[2:0]};
		if (a == 8'hB2)
			regs[a] = (v & 8'hBF) | {1'b0, v[7], 6'h00};
		if (a == 8'hB9)
			regs[a] = {v[7], v[6], v[7] & o[5], 3'h0,
				(v[1:0] == 2'h3) ? o[1:0] : v[1:0]};
		addr = a;
		wdata = v;
		wr = 1'b1;
		@(posedge clk_i);
		#2;
		wr = 1'b0;
		@(posedge clk_i);
		#2;
	end
	endtask : wr_reg
	task automatic rd_raw(input logic [7:0] a);
	begin
		addr = a;
		rd = 1'b1;
		@(posedge clk_i);
		#2;
		rd = 1'b0;
		@(posedge clk_i);
		#2;
	end
	endtask : rd_raw
	task automatic rd_reg(input logic [7:0] a);
	begin
		rd_raw(a);
		chk("sfr read", regs[a], rdata);
	end
	endtask : rd_reg
	initial
	begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		wrap_up();
	end
	initial
	begin
		k = $urandom(32'h05E48D7B);
		regs = '{default: 8'h00};
		regs[8'hB2] = 8'hC0;
		repeat (5) @(posedge clk_i);
		#2;
		reset_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#2;
		foreach (rlist[i]) rd_reg(rlist[i]);
		chk("ratio", 8'h04, {5'h00, ratio});
		for (k = 0; k < 4; k++)
		begin
			d = 8'(k) | (8'($urandom) & 8'h1C);
			wr_reg(8'hB9, d);
			rd_reg(8'hB9);
			chk("source", regs[8'hB9] & 8'h03, {6'h00, m_src});
		end
		wr_reg(8'hB9, 8'h40);
		rd_reg(8'hB9);
		wr_reg(8'hB1, 8'h67);
		repeat (40000) @(posedge clk_i);
		#2;
		regs[8'hB1] = regs[8'hB1] | 8'h80;
		rd_reg(8'hB1);
		chk("xosc", 8'h67, {1'b0, xmode, 1'b0, xrange});
		chk("periph", 8'h01, {7'h00, periph});
		wr_reg(8'hB9, 8'h00);
		wr_reg(8'hB9, 8'h01);
		wr_reg(8'hB9, 8'h81);
		chk("enable", 8'h01, {7'h00, m_en});
		repeat (210) @(posedge clk_i);
		#2;
		wr_reg(8'hB9, 8'hC1);
		k = 0;
		do
		begin
			repeat (10) @(posedge clk_i);
			#2;
			rd_raw(8'hB9);
			k++;
		end
		while (rdata[5] !== 1'b1 && k < 100);
		regs[8'hB9] = regs[8'hB9] | 8'h20;
		rd_reg(8'hB9);
		wr_reg(8'hA9, 8'h02);
		repeat (12) @(posedge clk_i);
		#2;
		chk("sys", {6'h00, 2'h2}, {6'h00, s_sel});
		for (k = 0; k < 5; k++)
		begin
			wr_reg(8'hA9, 8'h01 | 8'(k << 4));
			repeat (12) @(posedge clk_i);
			#2;
			rd_reg(8'hA9);
			chk("usb", 8'(k), {5'h00, u_sel});
			chk("sys", 8'h01, {6'h00, s_sel});
			chk("gate", 8'h03, {6'h00, s_gate, u_gate});
		end
		d = 8'h80 | (8'($urandom) & 8'h03);
		wr_reg(8'hB2, d);
		wr_reg(8'hA9, 8'h00);
		repeat (12) @(posedge clk_i);
		#2;
		chk("int osc", {d[7], 5'h00, d[1:0]}, {i_en, 5'h00, idiv});
		chk("sys", 8'h01, {5'h00, s_sel, s_gate});
		wr_reg(8'hB9, 8'h00);
		rd_reg(8'hB9);
		chk("mult", 8'h00, {6'h00, m_en, m_init});
		wr_reg(8'hA9, 8'h02);
		repeat (12) @(posedge clk_i);
		#2;
		chk("pending", 8'h00, {6'h00, s_sel});
		wrap_up();
	end
endmodule : tb
